// ### inc/ppm_pkg.sv
// ppm_pkg: constants shared by the port override mux and its alternate-function end
// assumes an 8-pin port; used by both ends and by the testbench
package ppm_pkg;
  localparam int PPM_PINS       = 8;
  localparam int PPM_ADDR_W     = 2;
  // register indices of the port, one 8-bit register each
  localparam logic [1:0] PPM_REG_DIR = 2'h0;  // direction bits
  localparam logic [1:0] PPM_REG_OUT = 2'h1;  // output bits
  localparam logic [1:0] PPM_REG_IN  = 2'h2;  // read: input samples, write 1: toggle
  localparam logic [1:0] PPM_REG_CFG = 2'h3;  // bit 0 global pull-up disable
  localparam int PPM_CFG_PUD_BIT = 0;
  localparam logic [7:0] PPM_RST_BYTE = 8'h00;
  // port B bit assignment
  localparam int PPM_BIT_T0A  = 7;
  localparam int PPM_BIT_T1B  = 6;
  localparam int PPM_BIT_T1A  = 5;
  localparam int PPM_BIT_T2A  = 4;
  localparam int PPM_BIT_MISO = 3;
  localparam int PPM_BIT_MOSI = 2;
  localparam int PPM_BIT_SCK  = 1;
  localparam int PPM_BIT_SS   = 0;
endpackage

// ### inc/ppm_if.sv
// ppm_if: per-pin override bundle between the port logic and the alternate functions
// assumes both ends share clk_i; all signals are per pin except global_pullup_disable
`timescale 1ns/1ns
interface ppm_if #(parameter int PINS = 8);
  logic [PINS-1:0] pullup_override_en;
  logic [PINS-1:0] pullup_override_val;
  logic [PINS-1:0] dir_override_en;
  logic [PINS-1:0] dir_override_val;
  logic [PINS-1:0] outval_override_en;
  logic [PINS-1:0] outval_override_val;
  logic [PINS-1:0] out_toggle_override_en;
  logic [PINS-1:0] input_enable_override_en;
  logic [PINS-1:0] input_enable_override_val;
  logic [PINS-1:0] raw_digital_input;
  logic [PINS-1:0] output_bit;
  logic            global_pullup_disable;
  modport port (
    input  pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
           outval_override_en, outval_override_val, out_toggle_override_en,
           input_enable_override_en, input_enable_override_val,
    output raw_digital_input, output_bit, global_pullup_disable
  );
  modport alt (
    output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
           outval_override_en, outval_override_val, out_toggle_override_en,
           input_enable_override_en, input_enable_override_val,
    input  raw_digital_input, output_bit, global_pullup_disable
  );
endinterface

// ### src/ppm_port.sv
// ppm_port: one 8-pin port with software registers and alternate-function overrides
// assumes pad inputs are asynchronous; override signals come from logic on clk_i
// How it works
// - override picks pull-up, else dir/out/pud 010
// - pull-up override value wins over all bits
// - direction override picks driver enable source
// - direction override value ignores software direction
// - driven level from override or output bit
// - value override ignores software output bit
// - toggle override inverts stored output bit
// - input enable from override or sleep state
// - input enable override ignores sleep state
// - raw input tapped before synchroniser
// - alternate functions synchronise raw input themselves
// - alternate functions generate override enables, values
// - strobes per port, clamp/pud shared, rest per pin
// - reset clears pull-ups
// - bit 7 carries timer0 compare A
// - bit 7 alternatively carries timer1 compare C
// - bit 7 raw input feeds pin change 7
// - bits 6..4 timer compares, pin change
// - bits 3..0 spi, programming data, pin change
// - global disable kills non-overridden pull-ups
// - writing 1 to input bit toggles output
`timescale 1ns/1ns
module ppm_port
  import ppm_pkg::*;
#(
  parameter int PINS = PPM_PINS
) (
  input  wire logic                  clk_i,        // port clock
  input  wire logic                  nrst_i,       // async reset, active low
  input  wire logic [PPM_ADDR_W-1:0] addr_i,       // register index
  input  wire logic [7:0]            wdata_i,      // write data
  input  wire logic                  port_write_strobe_i, // write strobe, whole port
  input  wire logic                  port_read_strobe_i,  // read strobe, whole port
  output logic      [7:0]            rdata_o,      // read data, cycle after strobe
  input  wire logic                  sleep_clamp_i, // shared sleep clamp of all ports
  input  wire logic [PINS-1:0]       pad_i,        // pad level after schmitt trigger
  output logic      [PINS-1:0]       pad_o,        // pad drive value
  output logic      [PINS-1:0]       pad_oe_o,     // pad drive enable
  output logic      [PINS-1:0]       pad_pullup_o, // pull-up enable
  ppm_if.port                        ovr           // alternate-function overrides
);
  logic [PINS-1:0] direction_bit_q;
  logic [PINS-1:0] output_bit_q;
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] input_sample_bit_q;
  logic            pud_q;
  logic [PINS-1:0] in_en;
  logic [PINS-1:0] gated_in;

  // hit: true when address a selects register idx
  function automatic logic hit(input logic [PPM_ADDR_W-1:0] a, input logic [PPM_ADDR_W-1:0] idx);
    return a == idx;
  endfunction

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      direction_bit_q <= PINS'(PPM_RST_BYTE);
    end else if (port_write_strobe_i && hit(addr_i, PPM_REG_DIR)) begin
      direction_bit_q <= wdata_i[PINS-1:0];
    end
  end

  // output bits: write, toggle by input-register write, toggle override
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_bit_q <= PINS'(PPM_RST_BYTE);
    end else begin
      if (port_write_strobe_i && hit(addr_i, PPM_REG_OUT)) begin
        output_bit_q <= wdata_i[PINS-1:0] ^ ovr.out_toggle_override_en;
      end else if (port_write_strobe_i && hit(addr_i, PPM_REG_IN)) begin
        output_bit_q <= output_bit_q ^ wdata_i[PINS-1:0] ^ ovr.out_toggle_override_en;
      end else begin
        output_bit_q <= output_bit_q ^ ovr.out_toggle_override_en;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pud_q <= 1'b0;
    end else if (port_write_strobe_i && hit(addr_i, PPM_REG_CFG)) begin
      pud_q <= wdata_i[PPM_CFG_PUD_BIT];
    end
  end

  // input path: enable, then two-stage synchroniser into the sample bits
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      in_en[i] = ovr.input_enable_override_en[i] ? ovr.input_enable_override_val[i]
                                                 : !sleep_clamp_i;
    end
  end
  assign gated_in = pad_i & in_en;
  assign ovr.raw_digital_input = gated_in;
  assign ovr.output_bit = output_bit_q;
  assign ovr.global_pullup_disable = pud_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q            <= PINS'(PPM_RST_BYTE);
      input_sample_bit_q <= PINS'(PPM_RST_BYTE);
    end else begin
      sync1_q            <= gated_in;
      input_sample_bit_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= PPM_RST_BYTE;
    end else if (port_read_strobe_i) begin
      if (hit(addr_i, PPM_REG_DIR)) begin
        rdata_o <= 8'(direction_bit_q);
      end else if (hit(addr_i, PPM_REG_OUT)) begin
        rdata_o <= 8'(output_bit_q);
      end else if (hit(addr_i, PPM_REG_IN)) begin
        rdata_o <= 8'(input_sample_bit_q);
      end else begin
        rdata_o <= {7'h00, pud_q};
      end
    end
  end

  // pad controls, registered per pin
  generate
    for (genvar g = 0; g < PINS; g++) begin : g_pin
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pad_oe_o[g]     <= 1'b0;
          pad_o[g]        <= 1'b0;
          pad_pullup_o[g] <= 1'b0;
        end else begin
          pad_oe_o[g] <= ovr.dir_override_en[g] ? ovr.dir_override_val[g]
                                                : direction_bit_q[g];
          // drive value is gated to zero while undriven
          pad_o[g] <= (ovr.dir_override_en[g] ? ovr.dir_override_val[g] : direction_bit_q[g])
                      & (ovr.outval_override_en[g] ? ovr.outval_override_val[g]
                                                   : output_bit_q[g]);
          pad_pullup_o[g] <= ovr.pullup_override_en[g] ? ovr.pullup_override_val[g]
                             : (!direction_bit_q[g] && output_bit_q[g] && !pud_q);
        end
      end
    end
  endgenerate
endmodule

// ### src/ppm_alt.sv
// ppm_alt: alternate-function side of port B, builds override enables and values
// assumes peripheral controls come from logic on clk_i
`timescale 1ns/1ns
module ppm_alt
  import ppm_pkg::*;
#(
  parameter int PINS = PPM_PINS
) (
  input  wire logic       clk_i,           // port clock
  input  wire logic       nrst_i,          // async reset, active low
  input  wire logic       t0_cmp_en_i,     // timer0 compare A drives bit 7
  input  wire logic       t0_cmp_i,        // timer0 compare A level
  input  wire logic       t1c_cmp_en_i,    // timer1 compare C drives bit 7
  input  wire logic       t1c_cmp_i,       // timer1 compare C level
  input  wire logic [2:0] cmp_en_i,        // enables for t1 B, t1 A, t2 A
  input  wire logic [2:0] cmp_i,           // levels for t1 B, t1 A, t2 A
  input  wire logic       spi_en_i,        // spi enabled
  input  wire logic       spi_master_i,    // spi is master
  input  wire logic       spi_slave_out_i, // slave data out, also programming data out
  input  wire logic       spi_mstr_out_i,  // master data out
  input  wire logic       spi_sck_out_i,   // clock out
  input  wire logic [7:0] pc_mask_i,       // pin change source mask
  input  wire logic       pc_enable_i,     // pin change group enable
  output logic      [7:0] pin_change_src_o, // synchronised inputs for pin change logic
  output logic      [3:0] spi_in_o,         // synchronised ss, sck, mosi, miso
  ppm_if.alt              ovr               // overrides toward the port
);
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic       sm;
  logic       ss;
  assign sm = spi_en_i & spi_master_i;
  assign ss = spi_en_i & ~spi_master_i;

  always_comb begin
    ovr.pullup_override_en        = '0;
    ovr.pullup_override_val       = '0;
    ovr.dir_override_en           = '0;
    ovr.dir_override_val          = '0;
    ovr.outval_override_en        = '0;
    ovr.outval_override_val       = '0;
    ovr.out_toggle_override_en    = '0;
    ovr.input_enable_override_en  = pc_mask_i & {8{pc_enable_i}};
    ovr.input_enable_override_val = '1;
    // timer0 A wins over timer1 C when both enabled
    ovr.outval_override_en[PPM_BIT_T0A]  = t0_cmp_en_i | t1c_cmp_en_i;
    ovr.outval_override_val[PPM_BIT_T0A] = t0_cmp_en_i ? t0_cmp_i : t1c_cmp_i;
    ovr.outval_override_en[PPM_BIT_T1B:PPM_BIT_T2A]  = cmp_en_i;
    ovr.outval_override_val[PPM_BIT_T1B:PPM_BIT_T2A] = cmp_i;
    ovr.pullup_override_en[PPM_BIT_MISO] = sm;
    ovr.dir_override_en[PPM_BIT_MISO]    = sm;
    ovr.outval_override_en[PPM_BIT_MISO] = ss;
    ovr.outval_override_val[PPM_BIT_MISO] = spi_slave_out_i;
    for (int i = PPM_BIT_SS; i <= PPM_BIT_MOSI; i++) begin
      ovr.pullup_override_en[i] = ss;
      ovr.dir_override_en[i]    = ss;
    end
    for (int i = PPM_BIT_SS; i <= PPM_BIT_MISO; i++) begin
      ovr.pullup_override_val[i] = ovr.output_bit[i] & ~ovr.global_pullup_disable;
    end
    ovr.outval_override_en[PPM_BIT_MOSI]  = sm;
    ovr.outval_override_val[PPM_BIT_MOSI] = spi_mstr_out_i;
    ovr.outval_override_en[PPM_BIT_SCK]   = sm;
    ovr.outval_override_val[PPM_BIT_SCK]  = spi_sck_out_i;
  end

  // own synchroniser on the raw inputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= ovr.raw_digital_input[7:0];
      sync2_q <= sync1_q;
    end
  end
  assign pin_change_src_o = sync2_q;
  assign spi_in_o = sync2_q[PPM_BIT_MISO:PPM_BIT_SS];
endmodule

// ### dv/ppm_props.sv
// ppm_props: checks on the override bundle and the pads of the port
// assumes one clock; pads follow their causes one cycle later
`timescale 1ns/1ns
module ppm_props #(
  parameter int PINS = 8
) (
  input wire logic            clk_i,                     // clock
  input wire logic            nrst_i,                    // reset, low
  input wire logic [PINS-1:0] pad_i,                     // pad level
  input wire logic            sleep_clamp_i,             // sleep clamp
  input wire logic [PINS-1:0] pad_o,                     // drive value
  input wire logic [PINS-1:0] pad_oe_o,                  // drive enable
  input wire logic [PINS-1:0] pad_pullup_o,              // pull-up
  input wire logic [PINS-1:0] pullup_override_en,        // ovr
  input wire logic [PINS-1:0] pullup_override_val,       // ovr
  input wire logic [PINS-1:0] dir_override_en,           // ovr
  input wire logic [PINS-1:0] dir_override_val,          // ovr
  input wire logic [PINS-1:0] outval_override_en,        // ovr
  input wire logic [PINS-1:0] outval_override_val,       // ovr
  input wire logic [PINS-1:0] out_toggle_override_en,    // ovr
  input wire logic [PINS-1:0] input_enable_override_en,  // ovr
  input wire logic [PINS-1:0] input_enable_override_val, // ovr
  input wire logic [PINS-1:0] raw_digital_input,         // raw input
  input wire logic [PINS-1:0] output_bit,                // stored outputs
  input wire logic            global_pullup_disable      // pud
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  pullup_ovr_a: assert property (
    (pad_pullup_o & $past(pullup_override_en)) ==
    ($past(pullup_override_val) & $past(pullup_override_en))) else $error("pull-up override");
  pullup_out_a: assert property (
    (pad_pullup_o & ~$past(pullup_override_en) & ~$past(output_bit)) == '0)
    else $error("pull-up without output bit");
  pud_off_a: assert property (
    $past(global_pullup_disable) |-> (pad_pullup_o & ~$past(pullup_override_en)) == '0)
    else $error("pull-up despite disable");
  dir_ovr_a: assert property (
    (pad_oe_o & $past(dir_override_en)) ==
    ($past(dir_override_val) & $past(dir_override_en))) else $error("direction override");
  val_ovr_a: assert property (
    (pad_o & $past(outval_override_en)) ==
    (pad_oe_o & $past(outval_override_en) & $past(outval_override_val)))
    else $error("value override");
  out_bit_a: assert property (
    (pad_o & ~$past(outval_override_en)) ==
    (pad_oe_o & ~$past(outval_override_en) & $past(output_bit))) else $error("output bit");
  undriven_low_a: assert property ((pad_o & ~pad_oe_o) == '0)
    else $error("value on undriven pad");
  toggle_flip_a: assert property (
    (|$past(out_toggle_override_en)) |-> ((output_bit ^ $past(output_bit)) &
    $past(out_toggle_override_en)) == $past(out_toggle_override_en)) else $error("toggle");
  input_ovr_a: assert property (
    (raw_digital_input & input_enable_override_en) ==
    (pad_i & input_enable_override_en & input_enable_override_val))
    else $error("input enable override");
  input_sleep_a: assert property (
    (raw_digital_input & ~input_enable_override_en) ==
    (pad_i & ~input_enable_override_en & ~{PINS{sleep_clamp_i}})) else $error("sleep clamp");
endmodule

// ### dv/tb_port_pin_override_mux.sv
// tb_port_pin_override_mux: port and alternate side joined by the bundle
// assumes 250 MHz clock; registers reached over the plain strobe port
`timescale 1ns/1ns
module tb_port_pin_override_mux;
  import ppm_pkg::*;
  logic       clk_i = 0;
  logic       nrst_i = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, pad_i = 0, pcm = 0, rdata, pad_o, pad_oe, pad_pu, pcs;
  logic [2:0] ce = 0, cv = 0;
  logic [3:0] spi_in;
  logic       ws = 0, rs = 0, slp = 0, t0e = 0, t0 = 0, t1e = 0, t1 = 0;
  logic       se = 0, sm = 0, sso = 0, smo = 0, sck = 0, pce = 0;
  int         errors = 0, n_checks = 0;
  always #2 clk_i = ~clk_i;
  ppm_if ovr ();
  // second port whose overrides the bench drives, to reach the toggle override
  ppm_if      tov ();
  logic [7:0] trd;
  ppm_port ppm_port_tgl_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .port_write_strobe_i(ws), .port_read_strobe_i(rs), .rdata_o(trd), .sleep_clamp_i(slp),
    .pad_i(pad_i), .pad_o(), .pad_oe_o(), .pad_pullup_o(), .ovr(tov.port));
  ppm_port ppm_port_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .port_write_strobe_i(ws), .port_read_strobe_i(rs), .rdata_o(rdata), .sleep_clamp_i(slp),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu), .ovr(ovr.port));
  ppm_alt ppm_alt_inst (.clk_i(clk_i), .nrst_i(nrst_i), .t0_cmp_en_i(t0e), .t0_cmp_i(t0),
    .t1c_cmp_en_i(t1e), .t1c_cmp_i(t1), .cmp_en_i(ce), .cmp_i(cv), .spi_en_i(se),
    .spi_master_i(sm), .spi_slave_out_i(sso), .spi_mstr_out_i(smo), .spi_sck_out_i(sck),
    .pc_mask_i(pcm), .pc_enable_i(pce), .pin_change_src_o(pcs), .spi_in_o(spi_in),
    .ovr(ovr.alt));
  ppm_props ppm_props_inst (.clk_i(clk_i), .nrst_i(nrst_i), .pad_i(pad_i),
    .sleep_clamp_i(slp), .pad_o(pad_o), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu),
    .pullup_override_en(ovr.pullup_override_en), .pullup_override_val(ovr.pullup_override_val),
    .dir_override_en(ovr.dir_override_en), .dir_override_val(ovr.dir_override_val),
    .outval_override_en(ovr.outval_override_en), .outval_override_val(ovr.outval_override_val),
    .out_toggle_override_en(ovr.out_toggle_override_en),
    .input_enable_override_en(ovr.input_enable_override_en),
    .input_enable_override_val(ovr.input_enable_override_val),
    .raw_digital_input(ovr.raw_digital_input), .output_bit(ovr.output_bit),
    .global_pullup_disable(ovr.global_pullup_disable));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i) {addr, wdata, ws} <= {a, d, 1'b1};
    @(posedge clk_i) ws <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i) {addr, rs} <= {a, 1'b1};
    @(posedge clk_i) rs <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // covers the one-cycle pad delay and the two-stage input sampling
  task automatic pads(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu);
    repeat (3) @(posedge clk_i);
    #1 chk(pad_oe, oe);
    chk(pad_o, o);
    chk(pad_pu, pu);
  endtask
  task automatic t_reset;
    pads(8'h00, 8'h00, 8'h00);
    rd(PPM_REG_OUT, 8'h00);
  endtask
  task automatic t_soft;
    wr(PPM_REG_DIR, 8'hF0);
    wr(PPM_REG_OUT, 8'h5A);
    pads(8'hF0, 8'h50, 8'h0A);
    rd(PPM_REG_DIR, 8'hF0);
    wr(PPM_REG_CFG, 8'h01);
    pads(8'hF0, 8'h50, 8'h00);
    rd(PPM_REG_CFG, 8'h01);
    wr(PPM_REG_CFG, 8'h00);
    wr(PPM_REG_IN, 8'h81);
    rd(PPM_REG_OUT, 8'hDB);
  endtask
  task automatic t_input;
    @(posedge clk_i) pad_i <= 8'h3C;
    pads(8'hF0, 8'hD0, 8'h0B);
    rd(PPM_REG_IN, 8'h3C);
    chk(pcs, 8'h3C);
    chk({4'h0, spi_in}, 8'h0C);
    @(posedge clk_i) {slp, pad_i, pce, pcm} <= {1'b1, 8'hBC, 1'b1, 8'h80};
    pads(8'hF0, 8'hD0, 8'h0B);
    rd(PPM_REG_IN, 8'h80);
    chk({7'h00, pcs[7]}, 8'h01);
    @(posedge clk_i) {slp, pce} <= 2'b00;
  endtask
  task automatic t_timer;
    wr(PPM_REG_DIR, 8'h7F);
    wr(PPM_REG_OUT, 8'h00);
    @(posedge clk_i) {t0e, t0} <= 2'b11;
    pads(8'h7F, 8'h00, 8'h00);
    wr(PPM_REG_DIR, 8'hFF);
    pads(8'hFF, 8'h80, 8'h00);
    @(posedge clk_i) {t0e, t1e, t1, ce, cv} <= {3'b011, 3'h7, 3'h5};
    pads(8'hFF, 8'hD0, 8'h00);
    @(posedge clk_i) {t1e, ce} <= 4'h0;
  endtask
  task automatic t_spi;
    wr(PPM_REG_OUT, 8'h0F);
    @(posedge clk_i) {se, sm, smo, sck, sso} <= 5'b11110;
    pads(8'hF7, 8'h07, 8'h08);
    @(posedge clk_i) sm <= 1'b0;
    pads(8'hF8, 8'h00, 8'h07);
    @(posedge clk_i) se <= 1'b0;
  endtask
  // toggle override held for one cycle flips the stored bits once
  task automatic t_toggle;
    wr(PPM_REG_OUT, 8'h0F);
    @(posedge clk_i) tov.out_toggle_override_en <= 8'h81;
    @(posedge clk_i) tov.out_toggle_override_en <= 8'h00;
    rd(PPM_REG_OUT, 8'h0F);
    chk(trd, 8'h8E);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
  initial begin
    {tov.pullup_override_en, tov.pullup_override_val, tov.dir_override_en,
     tov.dir_override_val, tov.outval_override_en, tov.outval_override_val,
     tov.out_toggle_override_en, tov.input_enable_override_en,
     tov.input_enable_override_val} <= 72'h0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_soft();
    t_input();
    t_timer();
    t_spi();
    t_toggle();
    report_and_stop();
  end
endmodule
